// ==== hdl/fdr_cmd_capture.sv ====
module fdr_cmd_capture
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic fifo_wr,
  input wire logic [7:0] wdata,
  input wire logic cmd_busy,
  output logic mfm_mode
);
  import fdr_pkg::*;

  fdr_cmd_e state_reg;
  fdr_cmd_e state_next;
  logic mfm_reg;
  logic mfm_next;
  logic is_rw;

  always_comb
  begin
    is_rw = (wdata[4:0] == OPC_READ_DATA) || (wdata[4:0] == OPC_READ_DELETED) ||
            (wdata[4:0] == OPC_WRITE_DATA) || (wdata[4:0] == OPC_WRITE_DELETED) ||
            (wdata[4:0] == OPC_READ_TRACK);
    state_next = state_reg;
    mfm_next = mfm_reg;
    unique case (state_reg)
      CMD_IDLE:
      begin
        if (fifo_wr && !cmd_busy)
        begin
          state_next = CMD_WAIT;
          if (is_rw)
          begin
            mfm_next = wdata[CMD_DENSITY_BIT];
          end
        end
      end
      CMD_WAIT:
      begin
        if (cmd_busy)
        begin
          state_next = CMD_BUSY;
        end
      end
      CMD_BUSY:
      begin
        if (!cmd_busy)
        begin
          state_next = CMD_IDLE;
        end
      end
      default: state_next = CMD_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= CMD_IDLE;
      mfm_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      mfm_reg <= mfm_next;
    end
  end

  assign mfm_mode = mfm_reg;

  a_density_latch: assert property (@(posedge clk) disable iff (!resetn)
    (state_reg == CMD_IDLE) && fifo_wr && !cmd_busy && is_rw
    |=> mfm_mode == $past(wdata[CMD_DENSITY_BIT]))
    else $error("density not taken from first command byte");
endmodule

// ==== hdl/fdr_pkg.sv ====
package fdr_pkg;
  localparam logic [2:0] OFS_STATUS_A = 3'h0;
  localparam logic [2:0] OFS_STATUS_B = 3'h1;
  localparam logic [2:0] OFS_DIG_OUT = 3'h2;
  localparam logic [2:0] OFS_TAPE = 3'h3;
  localparam logic [2:0] OFS_MAIN_RATE = 3'h4;
  localparam logic [2:0] OFS_FIFO = 3'h5;
  localparam logic [2:0] OFS_HOLE = 3'h6;
  localparam logic [2:0] OFS_DIN_CFG = 3'h7;
  localparam logic [7:0] FLOAT_READ = 8'hFF;
  localparam logic [7:0] HOLE_READ = 8'h00;
  localparam logic [7:0] DIG_OUT_RESET = 8'h00;
  localparam logic [1:0] TAPE_RESET = 2'h0;
  localparam logic [1:0] RATE_RESET = 2'h0;
  localparam logic [2:0] PRECOMP_RESET = 3'h0;
  localparam int RATE_SWRESET_BIT = 7;
  localparam int RATE_LOWPWR_BIT = 6;
  localparam int RATE_PRECOMP_LSB = 2;
  localparam int OUT_MOTOR_LSB = 4;
  localparam int OUT_DMA_BIT = 3;
  localparam int OUT_RESET_BIT = 2;
  localparam int CMD_DENSITY_BIT = 6;
  localparam logic [4:0] OPC_READ_DATA = 5'h06;
  localparam logic [4:0] OPC_READ_DELETED = 5'h0C;
  localparam logic [4:0] OPC_WRITE_DATA = 5'h05;
  localparam logic [4:0] OPC_WRITE_DELETED = 5'h09;
  localparam logic [4:0] OPC_READ_TRACK = 5'h02;

  typedef enum logic [1:0]
  {
    CMD_IDLE = 2'b00,
    CMD_WAIT = 2'b01,
    CMD_BUSY = 2'b11
  } fdr_cmd_e;

  typedef struct packed
  {
    logic irq_pending;
    logic step;
    logic head_select;
    logic head_dir;
    logic drv0_status;
    logic wdata_act;
    logic rdata_act;
    logic wgate;
    logic request_for_master;
    logic dio;
    logic non_dma;
    logic cmd_busy;
    logic [3:0] drv_busy;
    logic [7:0] fifo_rdata;
  } fdr_core_s;

  typedef struct packed
  {
    logic index;
    logic trk0;
    logic wp;
    logic disk_changed;
    logic first_media_sense;
    logic high_density;
    logic [1:0] drive_id;
    logic [1:0] drive_change;
  } fdr_drive_in_s;
endpackage

// ==== hdl/fdr_read_mux.sv ====
module fdr_read_mux
(
  input wire logic [2:0] addr,
  input wire logic ps2_mode,
  input wire logic tape_enh_mode,
  input wire logic pins_floated,
  input wire logic [7:0] dig_out,
  input wire logic [1:0] tape_sel,
  input wire logic [1:0] rate,
  input wire fdr_pkg::fdr_drive_in_s drv,
  input wire fdr_pkg::fdr_core_s core,
  output logic [7:0] rdata
);
  import fdr_pkg::*;

  always_comb
  begin
    rdata = HOLE_READ;
    if (pins_floated)
    begin
      rdata = FLOAT_READ;
    end
    else
    begin
      unique case (addr)
        OFS_STATUS_A:
        begin
          if (ps2_mode)
          begin
            rdata = {core.irq_pending, 1'b0, core.step, drv.trk0,
                     core.head_select, drv.index, drv.wp, core.head_dir};
          end
        end
        OFS_STATUS_B:
        begin
          if (ps2_mode)
          begin
            rdata = {2'b00, core.drv0_status, core.wdata_act, core.rdata_act,
                     core.wgate, dig_out[OUT_MOTOR_LSB+1], dig_out[OUT_MOTOR_LSB]};
          end
        end
        OFS_DIG_OUT: rdata = dig_out;
        OFS_TAPE:
        begin
          if (tape_enh_mode)
          begin
            rdata = {1'b1, drv.first_media_sense, drv.drive_id, drv.drive_change, tape_sel};
          end
          else
          begin
            rdata = {6'h00, tape_sel};
          end
        end
        OFS_MAIN_RATE:
        begin
          rdata = {core.request_for_master, core.dio, core.non_dma,
                   core.cmd_busy, core.drv_busy};
        end
        OFS_FIFO: rdata = core.fifo_rdata;
        OFS_HOLE: rdata = HOLE_READ;
        OFS_DIN_CFG:
        begin
          if (ps2_mode)
          begin
            rdata = {drv.disk_changed, 4'h0, rate, drv.high_density};
          end
          else
          begin
            rdata = {drv.disk_changed, 7'h00};
          end
        end
      endcase
    end
  end
endmodule

// ==== hdl/fdr_regs.sv ====
module fdr_regs
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [2:0] io_addr,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic io_rvalid,
  input wire logic ps2_mode,
  input wire logic tape_enh_mode,
  input wire logic pins_floated,
  input wire fdr_pkg::fdr_drive_in_s drive_in,
  input wire fdr_pkg::fdr_core_s core,
  output logic fifo_wr,
  output logic fifo_rd,
  output logic [7:0] fifo_wdata,
  output logic sw_reset,
  output logic low_power,
  output logic [2:0] precomp,
  output logic [3:0] motor_en,
  output logic [1:0] drive_sel,
  output logic dma_gate_enable,
  output logic ctrl_resetn,
  output logic [1:0] tape_sel,
  output logic lower_rate_output,
  output logic mfm_mode
);
  import fdr_pkg::*;

  logic [7:0] dig_out_reg;
  logic [7:0] dig_out_next;
  logic [1:0] tape_reg;
  logic [1:0] tape_next;
  logic [1:0] rate_reg;
  logic [1:0] rate_next;
  logic lowpwr_reg;
  logic lowpwr_next;
  logic [2:0] precomp_reg;
  logic [2:0] precomp_next;
  logic swreset_reg;
  logic swreset_next;

  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;
  logic fwr_reg;
  logic fwr_next;
  logic frd_reg;
  logic frd_next;
  logic [7:0] fwdata_reg;
  logic [7:0] fwdata_next;
  logic [7:0] mux_rdata;

  fdr_read_mux u_mux
  (
    .addr(io_addr),
    .ps2_mode(ps2_mode),
    .tape_enh_mode(tape_enh_mode),
    .pins_floated(pins_floated),
    .dig_out(dig_out_reg),
    .tape_sel(tape_reg),
    .rate(rate_reg),
    .drv(drive_in),
    .core(core),
    .rdata(mux_rdata)
  );

  fdr_cmd_capture u_cmd
  (
    .clk(clk),
    .resetn(resetn),
    .fifo_wr(fwr_reg),
    .wdata(fwdata_reg),
    .cmd_busy(core.cmd_busy),
    .mfm_mode(mfm_mode)
  );

  // write side of the register file
  always_comb
  begin
    dig_out_next = dig_out_reg;
    tape_next = tape_reg;
    rate_next = rate_reg;
    lowpwr_next = lowpwr_reg;
    precomp_next = precomp_reg;
    swreset_next = 1'b0;
    fwr_next = 1'b0;
    fwdata_next = fwdata_reg;
    if (io_wr)
    begin
      unique case (io_addr)
        OFS_DIG_OUT: dig_out_next = io_wdata;
        OFS_TAPE: tape_next = io_wdata[1:0];
        OFS_MAIN_RATE:
        begin
          swreset_next = io_wdata[RATE_SWRESET_BIT];
          lowpwr_next = io_wdata[RATE_LOWPWR_BIT];
          precomp_next = io_wdata[RATE_PRECOMP_LSB+2:RATE_PRECOMP_LSB];
          rate_next = io_wdata[1:0];
        end
        OFS_FIFO:
        begin
          fwr_next = 1'b1;
          fwdata_next = io_wdata;
        end
        OFS_DIN_CFG: rate_next = io_wdata[1:0];
        OFS_STATUS_A, OFS_STATUS_B, OFS_HOLE:
        begin
          dig_out_next = dig_out_reg;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      dig_out_reg <= DIG_OUT_RESET;
      tape_reg <= TAPE_RESET;
      rate_reg <= RATE_RESET;
      lowpwr_reg <= 1'b0;
      precomp_reg <= PRECOMP_RESET;
      swreset_reg <= 1'b0;
      fwr_reg <= 1'b0;
      fwdata_reg <= 8'h00;
    end
    else
    begin
      dig_out_reg <= dig_out_next;
      tape_reg <= tape_next;
      rate_reg <= rate_next;
      lowpwr_reg <= lowpwr_next;
      precomp_reg <= precomp_next;
      swreset_reg <= swreset_next;
      fwr_reg <= fwr_next;
      fwdata_reg <= fwdata_next;
    end
  end

  // read side, one cycle after the strobe
  always_comb
  begin
    rvalid_next = io_rd;
    rdata_next = rdata_reg;
    frd_next = 1'b0;
    if (io_rd)
    begin
      rdata_next = mux_rdata;
      frd_next = (io_addr == OFS_FIFO) && !pins_floated;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
      frd_reg <= 1'b0;
    end
    else
    begin
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
      frd_reg <= frd_next;
    end
  end

  // drive pins: no upper rate output and no second media sense exist
  assign io_rdata = rdata_reg;
  assign io_rvalid = rvalid_reg;
  assign fifo_wr = fwr_reg;
  assign fifo_wdata = fwdata_reg;
  assign fifo_rd = frd_reg;
  assign sw_reset = swreset_reg;
  assign low_power = lowpwr_reg;
  assign precomp = precomp_reg;
  assign motor_en = dig_out_reg[OUT_MOTOR_LSB+3:OUT_MOTOR_LSB];
  assign drive_sel = dig_out_reg[1:0];
  assign dma_gate_enable = dig_out_reg[OUT_DMA_BIT];
  assign ctrl_resetn = dig_out_reg[OUT_RESET_BIT];
  assign tape_sel = tape_reg;
  assign lower_rate_output = rate_reg[0];

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  sequence s_read(logic [2:0] a);
    io_rd && (io_addr == a) && !pins_floated;
  endsequence

  sequence s_write(logic [2:0] a);
    io_wr && (io_addr == a);
  endsequence

  a_float_all_ones: assert property (io_rd && pins_floated |=>
    io_rvalid && io_rdata == 8'hFF)
    else $error("floated read did not return all ones");

  a_float_no_pop: assert property (io_rd && pins_floated |=> !fifo_rd)
    else $error("floated read popped the command fifo");

  a_rvalid_pulse: assert property (1'b1 |=> io_rvalid == $past(io_rd))
    else $error("read valid not one cycle after strobe");

  a_rdata_hold: assert property (!io_rd |=> $stable(io_rdata))
    else $error("read data moved without a read");

  a_main_status: assert property (s_read(OFS_MAIN_RATE) |=>
    io_rdata == {$past(core.request_for_master), $past(core.dio), $past(core.non_dma),
    $past(core.cmd_busy), $past(core.drv_busy)})
    else $error("main status layout wrong");

  a_rate_write: assert property (s_write(OFS_MAIN_RATE) |=>
    rate_reg == $past(io_wdata[1:0]) &&
    precomp == $past(io_wdata[RATE_PRECOMP_LSB+2:RATE_PRECOMP_LSB]) &&
    low_power == $past(io_wdata[RATE_LOWPWR_BIT]) &&
    sw_reset == $past(io_wdata[RATE_SWRESET_BIT]))
    else $error("rate select write not loaded");

  a_swreset_pulse: assert property (sw_reset |=> !sw_reset ||
    $past(io_wr && io_addr == OFS_MAIN_RATE && io_wdata[RATE_SWRESET_BIT]))
    else $error("software reset pulse too long");

  a_precomp_hold: assert property (!(io_wr && io_addr == OFS_MAIN_RATE) |=>
    $stable(precomp) && $stable(low_power) && !sw_reset)
    else $error("rate select fields moved without a write");

  a_config_write: assert property (s_write(OFS_DIN_CFG) |=>
    rate_reg == $past(io_wdata[1:0]) && lower_rate_output == $past(io_wdata[0]) &&
    $stable(precomp) && $stable(low_power))
    else $error("configuration write wrong");

  a_hole_ignored: assert property (s_write(OFS_HOLE) |=>
    $stable(dig_out_reg) && $stable(rate_reg) && $stable(tape_reg) && !fifo_wr)
    else $error("write to hole changed state");

  a_status_ro: assert property ((s_write(OFS_STATUS_A) or s_write(OFS_STATUS_B)) |=>
    $stable(dig_out_reg) && $stable(rate_reg) && $stable(tape_reg) && !fifo_wr)
    else $error("write to status register changed state");

  a_hole_read: assert property (s_read(OFS_HOLE) |=> io_rdata == 8'h00)
    else $error("hole read not zero");

  a_at_input: assert property (s_read(OFS_DIN_CFG) ##0 !ps2_mode |=>
    io_rdata == {$past(drive_in.disk_changed), 7'h00})
    else $error("pc-at digital input wrong");

  a_ps2_input: assert property (s_read(OFS_DIN_CFG) ##0 ps2_mode |=>
    io_rdata == {$past(drive_in.disk_changed), 4'h0, $past(rate_reg),
    $past(drive_in.high_density)})
    else $error("ps2 digital input wrong");

  a_ps2_only: assert property ((s_read(OFS_STATUS_A) or s_read(OFS_STATUS_B)) ##0
    !ps2_mode |=> io_rdata == 8'h00)
    else $error("status a or b visible outside ps2 mode");

  a_status_a_bits: assert property (s_read(OFS_STATUS_A) ##0 ps2_mode |=>
    io_rdata == {$past(core.irq_pending), 1'b0, $past(core.step), $past(drive_in.trk0),
    $past(core.head_select), $past(drive_in.index), $past(drive_in.wp),
    $past(core.head_dir)})
    else $error("status a layout wrong");

  a_status_b_bits: assert property (s_read(OFS_STATUS_B) ##0 ps2_mode |=>
    io_rdata == {2'b00, $past(core.drv0_status), $past(core.wdata_act),
    $past(core.rdata_act), $past(core.wgate), $past(motor_en[1:0])})
    else $error("status b layout wrong");

  a_tape_enh: assert property (s_read(OFS_TAPE) ##0 tape_enh_mode |=>
    io_rdata == {1'b1, $past(drive_in.first_media_sense), $past(drive_in.drive_id),
    $past(drive_in.drive_change), $past(tape_sel)})
    else $error("enhanced tape register wrong");

  a_tape_plain: assert property (s_read(OFS_TAPE) ##0 !tape_enh_mode |=>
    io_rdata == {6'h00, $past(tape_sel)})
    else $error("plain tape register wrong");

  a_tape_write: assert property (s_write(OFS_TAPE) |=> tape_sel == $past(io_wdata[1:0]))
    else $error("tape select write not loaded");

  a_dig_out_write: assert property (s_write(OFS_DIG_OUT) |=>
    motor_en == $past(io_wdata[7:4]) && dma_gate_enable == $past(io_wdata[3]) &&
    ctrl_resetn == $past(io_wdata[2]) && drive_sel == $past(io_wdata[1:0]))
    else $error("digital output write not loaded");

  a_dig_out_hold: assert property (!(io_wr && io_addr == OFS_DIG_OUT) |=>
    $stable(dig_out_reg))
    else $error("digital output changed without a write");

  a_fifo_pulse: assert property (s_write(OFS_FIFO) |=> fifo_wr && fifo_wdata ==
    $past(io_wdata) ##1 (!fifo_wr || $past(io_wr && io_addr == OFS_FIFO)))
    else $error("fifo write pulse wrong");

  a_fifo_data_hold: assert property (!(io_wr && io_addr == OFS_FIFO) |=>
    $stable(fifo_wdata) && !fifo_wr)
    else $error("fifo write data moved without a write");

  a_fifo_read: assert property (s_read(OFS_FIFO) |=> fifo_rd)
    else $error("fifo read pulse missing");
endmodule

// ==== test/fdr_host.sv ====
module fdr_host
(
  input wire logic clk,
  output logic [2:0] io_addr,
  output logic io_rd,
  output logic io_wr,
  output logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic io_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    io_addr = 3'h0;
    io_rd = 1'b0;
    io_wr = 1'b0;
    io_wdata = 8'h00;
  end
  // one write strobe, then released lines show inverted values
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    io_addr <= a;
    io_wr <= 1'b1;
    io_wdata <= d;
    @(posedge clk);
    io_wr <= 1'b0;
    io_addr <= ~a;
    io_wdata <= ~d;
  endtask
  // data and valid taken in the answer cycle
  task automatic rd(input logic [2:0] a, output logic [7:0] d, output logic v);
    @(posedge clk);
    io_addr <= a;
    io_rd <= 1'b1;
    @(posedge clk);
    io_rd <= 1'b0;
    io_addr <= ~a;
    @(posedge clk);
    d = io_rdata;
    v = io_rvalid;
  endtask
endmodule

// ==== test/tb_top.sv ====
module tb_top;
  import fdr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, resetn, ps2_mode, tape_enh_mode, pins_floated;
  fdr_drive_in_s drive_in;
  fdr_core_s core;
  logic [2:0] io_addr, precomp;
  logic io_rd, io_wr, io_rvalid, fifo_wr, fifo_rd, sw_reset, low_power;
  logic dma_gate_enable, ctrl_resetn, lower_rate_output, mfm_mode;
  logic [7:0] io_wdata, io_rdata, fifo_wdata, rv;
  logic [3:0] motor_en;
  logic [1:0] drive_sel, tape_sel;
  logic vv;
  int miscompares, checked;
  fdr_host host (.clk, .io_addr, .io_rd, .io_wr, .io_wdata, .io_rdata, .io_rvalid);
  fdr_regs dut (.clk, .resetn, .io_addr, .io_rd, .io_wr, .io_wdata, .io_rdata,
    .io_rvalid, .ps2_mode, .tape_enh_mode, .pins_floated, .drive_in, .core,
    .fifo_wr, .fifo_rd, .fifo_wdata, .sw_reset, .low_power, .precomp, .motor_en,
    .drive_sel, .dma_gate_enable, .ctrl_resetn, .tape_sel, .lower_rate_output,
    .mfm_mode);
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // read with valid pulse check
  task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
    host.rd(a, rv, vv);
    chk({7'h00, vv}, 8'h01);
    chk(rv, exp);
  endtask
  task automatic summarize;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic t_reset;
    chk({ctrl_resetn, mfm_mode, lower_rate_output, dma_gate_enable, motor_en}, 8'h00);
    rdc(OFS_DIG_OUT, DIG_OUT_RESET);
    $display("done reset");
  endtask
  task automatic t_regs;
    host.wr(OFS_DIG_OUT, 8'hA5);
    #1;
    chk({motor_en, dma_gate_enable, ctrl_resetn, drive_sel}, 8'hA5);
    rdc(OFS_DIG_OUT, 8'hA5);
    host.wr(OFS_MAIN_RATE, 8'hD7);
    #1;
    chk({2'h0, sw_reset, low_power, precomp, lower_rate_output}, 8'h3B);
    @(posedge clk);
    #1;
    chk({7'h00, sw_reset}, 8'h00);
    @(posedge clk);
    core.request_for_master <= 1'b1;
    core.dio <= 1'b1;
    core.non_dma <= 1'b1;
    core.drv_busy <= 4'h9;
    rdc(OFS_MAIN_RATE, 8'hE9);
    host.wr(OFS_DIN_CFG, 8'h02);
    #1;
    chk({7'h00, lower_rate_output}, 8'h00);
    $display("done regs");
  endtask
  task automatic t_status;
    @(posedge clk);
    ps2_mode <= 1'b1;
    core.irq_pending <= 1'b1;
    core.head_select <= 1'b1;
    core.drv0_status <= 1'b1;
    drive_in.trk0 <= 1'b1;
    drive_in.wp <= 1'b1;
    drive_in.disk_changed <= 1'b1;
    drive_in.high_density <= 1'b1;
    rdc(OFS_STATUS_A, 8'h9A);
    rdc(OFS_STATUS_B, 8'h22);
    rdc(OFS_DIN_CFG, 8'h85);
    @(posedge clk);
    core.irq_pending <= 1'b0;
    core.step <= 1'b1;
    core.head_select <= 1'b0;
    core.head_dir <= 1'b1;
    drive_in.index <= 1'b1;
    drive_in.trk0 <= 1'b0;
    drive_in.wp <= 1'b0;
    core.drv0_status <= 1'b0;
    core.wdata_act <= 1'b1;
    core.rdata_act <= 1'b1;
    core.wgate <= 1'b1;
    drive_in.high_density <= 1'b0;
    rdc(OFS_STATUS_A, 8'h25);
    rdc(OFS_STATUS_B, 8'h1E);
    rdc(OFS_DIN_CFG, 8'h84);
    @(posedge clk);
    ps2_mode <= 1'b0;
    rdc(OFS_STATUS_A, 8'h00);
    rdc(OFS_STATUS_B, 8'h00);
    rdc(OFS_DIN_CFG, 8'h80);
    rdc(OFS_DIG_OUT, 8'hA5);
    $display("done status");
  endtask
  task automatic t_tape;
    host.wr(OFS_TAPE, 8'hFE);
    @(posedge clk);
    tape_enh_mode <= 1'b1;
    drive_in.first_media_sense <= 1'b1;
    drive_in.drive_id <= 2'h2;
    drive_in.drive_change <= 2'h1;
    rdc(OFS_TAPE, 8'hE6);
    chk({6'h00, tape_sel}, 8'h02);
    @(posedge clk);
    tape_enh_mode <= 1'b0;
    rdc(OFS_TAPE, 8'h02);
    $display("done tape");
  endtask
  task automatic t_hole;
    host.wr(OFS_HOLE, 8'hFF);
    host.wr(OFS_STATUS_A, 8'hFF);
    rdc(OFS_DIG_OUT, 8'hA5);
    rdc(OFS_HOLE, HOLE_READ);
    $display("done hole");
  endtask
  task automatic t_density;
    host.wr(OFS_FIFO, 8'h45);
    #1;
    chk(fifo_wdata, 8'h45);
    chk({7'h00, fifo_wr}, 8'h01);
    @(posedge clk);
    #1;
    chk({7'h00, mfm_mode}, 8'h01);
    @(posedge clk);
    core.cmd_busy <= 1'b1;
    repeat (3) @(posedge clk);
    core.cmd_busy <= 1'b0;
    host.wr(OFS_FIFO, 8'h06);
    @(posedge clk);
    #1;
    chk({7'h00, mfm_mode}, 8'h00);
    @(posedge clk);
    core.fifo_rdata <= 8'h3C;
    rdc(OFS_FIFO, 8'h3C);
    chk({7'h00, fifo_rd}, 8'h01);
    $display("done density");
  endtask
  task automatic t_float;
    @(posedge clk);
    pins_floated <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      rdc(i[2:0], FLOAT_READ);
      chk({7'h00, fifo_rd}, 8'h00);
    end
    @(posedge clk);
    pins_floated <= 1'b0;
    $display("done float");
  endtask
  initial
  begin
    miscompares = 0;
    checked = 0;
    ps2_mode = 1'b0;
    tape_enh_mode = 1'b0;
    pins_floated = 1'b0;
    drive_in = '0;
    core = '0;
    resetn = 1'b0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    t_reset;
    t_regs;
    t_status;
    t_tape;
    t_hole;
    t_density;
    t_float;
    summarize;
  end
  initial
  begin
    repeat (3000) @(posedge clk);
    miscompares++;
    summarize;
  end
endmodule
